/* src/arw_pkg.sv */
/*
 * Constants shared by the converter result, window and trim register logic.
 * Assumes byte offsets on an 8-bit register address and 16-bit register data.
 */
package arw_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_AVG = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_FLAG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h19;
    localparam logic [7:0] OFS_RESULT = 8'h1A;
    localparam logic [7:0] OFS_WINLO = 8'h1C;
    localparam logic [7:0] OFS_WINHI = 8'h20;
    localparam logic [7:0] OFS_GAIN = 8'h24;
    localparam logic [7:0] OFS_OFFS = 8'h26;
    localparam logic [7:0] OFS_FACT = 8'h28;
    localparam logic [7:0] OFS_DBG = 8'h2A;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_LEFT = 1;
    localparam int CTRL_TRIM = 2;
    localparam int CTRL_WINEN = 3;
    localparam int AVG_CNT_LSB = 0;
    localparam int AVG_SHIFT_LSB = 4;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_LOST = 1;
    localparam int FLAG_WIN = 2;
    localparam int FLAG_SYNC = 3;
    localparam int STATUS_SYNC = 7;
    localparam int FACT_BIAS_LSB = 8;
    localparam int FACT_LIN_LSB = 0;
    localparam int DBG_RUN = 0;
    localparam int TRIM_FRAC = 11;
    // ****************************************
    // Reset values, counts and limits
    // ****************************************
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] SYNC_LEN = 4'h3;
    localparam logic [15:0] MAX_NARROW = 16'h0FFF;
    localparam logic [15:0] MAX_WIDE = 16'hFFFF;

    // Clamp a signed value to the active result width
    function automatic logic [15:0] arw_sat(input logic signed [19:0] v, input logic wide);
        logic [15:0] lim;
        lim = wide ? MAX_WIDE : MAX_NARROW;
        if (v < 0) begin
            return 16'h0000;
        end else if (v > $signed({4'h0, lim})) begin
            return lim;
        end
        return v[15:0];
    endfunction
endpackage

/* src/arw_trim.sv */
/*
 * Offset and gain trim of one conversion value, combinational.
 * Assumes the caller stores the trimmed value on its own clock.
 */
`timescale 1ns/1ps
`default_nettype none
module arw_trim (
    input wire logic [15:0] rawVal,
    input wire logic [11:0] gainTrim,
    input wire logic [11:0] offsetTrim,
    input wire logic apply,
    input wire logic wide,
    output logic [15:0] trimVal
);
    import arw_pkg::*;

    logic signed [17:0] diff;
    logic signed [30:0] prod;
    logic signed [19:0] scaled;

    always_comb begin
        // Offset first, then gain 1.11 fixed point
        diff = $signed({2'b00, rawVal}) - $signed({{6{offsetTrim[11]}}, offsetTrim});
        prod = diff * $signed({1'b0, gainTrim});
        scaled = prod[30:TRIM_FRAC];
        trimVal = apply ? arw_sat(scaled, wide) : rawVal;
    end
endmodule
`default_nettype wire

/* src/arw_format.sv */
/*
 * Result layout and window comparison, combinational.
 * Assumes storedVal is the value already held in the result register.
 */
`timescale 1ns/1ps
`default_nettype none
module arw_format (
    input wire logic [15:0] value,
    input wire logic leftJustify,
    input wire logic overSampled,
    input wire logic [15:0] storedVal,
    input wire logic windowEnable,
    input wire logic [15:0] windowLowLimit,
    input wire logic [15:0] windowHighLimit,
    output logic [15:0] placed,
    output logic winMatch
);
    always_comb begin
        if (overSampled) begin
            placed = value;
        end else if (leftJustify) begin
            placed = {value[11:0], 4'h0};
        end else begin
            placed = {4'h0, value[11:0]};
        end
        // Compare in result register alignment
        winMatch = windowEnable && (storedVal >= windowLowLimit)
            && (storedVal <= windowHighLimit);
    end
endmodule
`default_nettype wire

/* src/arw_regs.sv */
/*
 * Converter result, window monitor and trim registers with flags and interrupt.
 * Assumes a single clock, a one-cycle strobed register port and a converter
 * core that pulses sampleValid with a 12-bit sample.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module arw_regs #(
    parameter logic [3:0] SYNC_CYCLES = arw_pkg::SYNC_LEN
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [15:0] regRdData,
    input wire logic sampleValid,
    input wire logic [11:0] sampleData,
    input wire logic debugHalt,
    output logic convRun,
    output logic syncInProgress,
    output logic irq,
    output logic [2:0] biasTrim,
    output logic [7:0] linearityTrim
);
    import arw_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [15:0] result;
        logic [15:0] winLo;
        logic [15:0] winHi;
        logic [11:0] gain;
        logic [11:0] offs;
        logic [2:0] bias;
        logic [7:0] lin;
        logic runHalted;
        logic enable;
        logic leftJust;
        logic trimApply;
        logic winEn;
        logic [2:0] avgCnt;
        logic [2:0] avgShift;
        logic [3:0] flags;
        logic [3:0] mask;
        logic unread;
        logic [3:0] syncCnt;
        logic sync;
        logic [18:0] acc;
        logic [7:0] sampleCnt;
        logic winPend;
        logic [15:0] rdData;
        logic irq;
        logic convRun;
    } arw_state_t;

    arw_state_t q;
    arw_state_t d;

    logic runNow;
    logic overSampled;
    logic lastSample;
    logic storeEv;
    logic [18:0] accSum;
    logic [18:0] accShift;
    logic [7:0] lastIdx;
    logic [15:0] avgVal;
    logic [15:0] preVal;
    logic [15:0] trimVal;
    logic [15:0] placed;
    logic winMatch;

    // ****************************************
    // Sample path
    // ****************************************
    assign runNow = q.enable && (!debugHalt || q.runHalted);
    assign overSampled = (q.avgCnt != 3'h0);
    assign lastIdx = (8'h01 << q.avgCnt) - 8'h01;
    assign lastSample = !overSampled || (q.sampleCnt == lastIdx);
    assign storeEv = sampleValid && runNow && lastSample;
    assign accSum = q.acc + {7'h00, sampleData};
    assign accShift = accSum >> q.avgShift;
    assign avgVal = arw_sat($signed({1'b0, accShift}), 1'b1);
    assign preVal = overSampled ? avgVal : {4'h0, sampleData};

    arw_trim u_trim (
        .rawVal(preVal),
        .gainTrim(q.gain),
        .offsetTrim(q.offs),
        .apply(q.trimApply),
        .wide(overSampled),
        .trimVal(trimVal)
    );

    arw_format u_format (
        .value(trimVal),
        .leftJustify(q.leftJust),
        .overSampled(overSampled),
        .storedVal(q.result),
        .windowEnable(q.winEn),
        .windowLowLimit(q.winLo),
        .windowHighLimit(q.winHi),
        .placed(placed),
        .winMatch(winMatch)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.rdData = RST_WORD;
        // Transfer countdown
        if (q.syncCnt != 4'h0) begin
            d.syncCnt = q.syncCnt - 4'h1;
        end
        // Register writes
        if (regWrStrobe) begin
            if (regAddr == OFS_CTRL) begin
                d.enable = regWrData[CTRL_ENABLE];
                d.leftJust = regWrData[CTRL_LEFT];
                d.trimApply = regWrData[CTRL_TRIM];
                d.winEn = regWrData[CTRL_WINEN];
                d.syncCnt = SYNC_CYCLES;
            end else if (regAddr == OFS_AVG) begin
                d.avgCnt = regWrData[AVG_CNT_LSB +: 3];
                d.avgShift = regWrData[AVG_SHIFT_LSB +: 3];
            end else if (regAddr == OFS_MASK) begin
                d.mask = regWrData[3:0];
            end else if (regAddr == OFS_FLAG) begin
                d.flags = q.flags & ~regWrData[3:0];
            end else if (regAddr == OFS_WINLO) begin
                d.winLo = regWrData;
                d.syncCnt = SYNC_CYCLES;
            end else if (regAddr == OFS_WINHI) begin
                d.winHi = regWrData;
                d.syncCnt = SYNC_CYCLES;
            end else if (regAddr == OFS_GAIN) begin
                d.gain = regWrData[11:0];
            end else if (regAddr == OFS_OFFS) begin
                d.offs = regWrData[11:0];
            end else if (regAddr == OFS_FACT) begin
                d.bias = regWrData[FACT_BIAS_LSB +: 3];
                d.lin = regWrData[FACT_LIN_LSB +: 8];
            end else if (regAddr == OFS_DBG) begin
                if (!q.enable) begin
                    d.runHalted = regWrData[DBG_RUN];
                end
            end
        end
        // Register reads
        if (regRdStrobe) begin
            if (regAddr == OFS_CTRL) begin
                d.rdData = {12'h000, q.winEn, q.trimApply, q.leftJust, q.enable};
            end else if (regAddr == OFS_AVG) begin
                d.rdData = {9'h000, q.avgShift, 1'b0, q.avgCnt};
            end else if (regAddr == OFS_MASK) begin
                d.rdData = {12'h000, q.mask};
            end else if (regAddr == OFS_FLAG) begin
                d.rdData = {12'h000, q.flags};
            end else if (regAddr == OFS_STATUS) begin
                d.rdData = RST_WORD;
                d.rdData[STATUS_SYNC] = q.sync;
            end else if (regAddr == OFS_RESULT) begin
                d.rdData = q.result;
                d.flags[FLAG_DONE] = 1'b0;
                d.flags[FLAG_WIN] = 1'b0;
                d.unread = 1'b0;
            end else if (regAddr == OFS_WINLO) begin
                d.rdData = q.winLo;
            end else if (regAddr == OFS_WINHI) begin
                d.rdData = q.winHi;
            end else if (regAddr == OFS_GAIN) begin
                d.rdData = {4'h0, q.gain};
            end else if (regAddr == OFS_OFFS) begin
                d.rdData = {4'h0, q.offs};
            end else if (regAddr == OFS_FACT) begin
                d.rdData = {5'h00, q.bias, q.lin};
            end else if (regAddr == OFS_DBG) begin
                d.rdData = {15'h0000, q.runHalted};
            end
        end
        // Sync busy follows the countdown
        d.sync = (d.syncCnt != 4'h0);
        if (q.sync && !d.sync) begin
            d.flags[FLAG_SYNC] = 1'b1;
        end
        // Accumulation
        if (!q.enable) begin
            d.acc = 19'h00000;
            d.sampleCnt = 8'h00;
        end else if (sampleValid && runNow && overSampled) begin
            if (lastSample) begin
                d.acc = 19'h00000;
                d.sampleCnt = 8'h00;
            end else begin
                d.acc = accSum;
                d.sampleCnt = q.sampleCnt + 8'h01;
            end
        end
        // Result store, setting wins over clearing
        d.winPend = storeEv;
        if (storeEv) begin
            d.result = placed;
            d.flags[FLAG_DONE] = 1'b1;
            if (q.unread) begin
                d.flags[FLAG_LOST] = 1'b1;
            end
            d.unread = 1'b1;
        end
        if (q.winPend && winMatch) begin
            d.flags[FLAG_WIN] = 1'b1;
        end
        d.irq = |(d.flags & d.mask);
        d.convRun = runNow;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign regRdData = q.rdData;
    assign convRun = q.convRun;
    assign syncInProgress = q.sync;
    assign irq = q.irq;
    assign biasTrim = q.bias;
    assign linearityTrim = q.lin;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    property p_syncStart;
        regWrStrobe && (regAddr == OFS_WINLO) |=> syncInProgress [*3];
    endproperty
    a_syncStart: assert property (p_syncStart) else $error("sync busy not held");

    property p_syncDone;
        $fell(syncInProgress) |-> q.flags[FLAG_SYNC];
    endproperty
    a_syncDone: assert property (p_syncDone) else $error("sync end not flagged");

    property p_rightJust;
        storeEv && !overSampled && !q.leftJust |=> q.result[15:12] == 4'h0;
    endproperty
    a_rightJust: assert property (p_rightJust) else $error("right justify high bits set");

    property p_leftJust;
        storeEv && !overSampled && q.leftJust |=> q.result[3:0] == 4'h0;
    endproperty
    a_leftJust: assert property (p_leftJust) else $error("left justify low bits set");

    property p_readClear;
        regRdStrobe && (regAddr == OFS_RESULT) && !storeEv && !(q.winPend && winMatch)
            |=> !q.flags[FLAG_DONE] && !q.flags[FLAG_WIN];
    endproperty
    a_readClear: assert property (p_readClear) else $error("result read left flags");

    property p_lost;
        storeEv && q.unread |=> q.flags[FLAG_LOST] && q.flags[FLAG_DONE];
    endproperty
    a_lost: assert property (p_lost) else $error("overwrite not flagged");

    property p_winHit;
        storeEv ##1 winMatch |=> q.flags[FLAG_WIN];
    endproperty
    a_winHit: assert property (p_winHit) else $error("window hit missed");

    property p_dbgLock;
        q.enable && regWrStrobe && (regAddr == OFS_DBG) |=> $stable(q.runHalted);
    endproperty
    a_dbgLock: assert property (p_dbgLock) else $error("debug bit changed while enabled");

    property p_halt;
        debugHalt && !q.runHalted |=> !convRun;
    endproperty
    a_halt: assert property (p_halt) else $error("converter ran while halted");

    property p_noTrim;
        !q.trimApply |-> trimVal == preVal;
    endproperty
    a_noTrim: assert property (p_noTrim) else $error("trim applied while off");

    property p_irq;
        |(q.flags & q.mask) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    c_store: cover property (storeEv ##1 regRdStrobe && (regAddr == OFS_RESULT));
    c_lost: cover property (storeEv && q.unread);
    c_win: cover property (q.winPend && winMatch);
    c_sync: cover property ($fell(syncInProgress));
endmodule
`default_nettype wire

/* verif/arw_tb.sv */
/*
 * Self-checking bench for the converter result, window and trim registers.
 * Assumes arw_pkg and arw_regs are compiled first; one clock at 40 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin nCompared++; if ((act) !== (exp)) begin numErrors++; \
    $display("unexpected at %0t: got %h, want %h", $time, (act), (exp)); end end
module testbench;
    import arw_pkg::*;
    localparam logic [3:0] SYNC_N = 4'h3;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [15:0] regRdData;
    logic sampleValid = 1'b0;
    logic [11:0] sampleData = 12'h000;
    logic debugHalt = 1'b0;
    logic convRun;
    logic syncInProgress;
    logic irq;
    logic [2:0] biasTrim;
    logic [7:0] linearityTrim;
    int numErrors = 0;
    int nCompared = 0;
    logic [15:0] rdVal;
    logic [7:0] rstOfs [13] = '{OFS_AVG, OFS_CTRL, OFS_MASK, OFS_FLAG, OFS_STATUS, OFS_RESULT,
        OFS_WINLO, OFS_WINHI, OFS_GAIN, OFS_OFFS, OFS_FACT, OFS_DBG, 8'h30};
    // Gain, offset, raw sample, expected result
    logic [15:0] trimTab [4][4] = '{'{16'h0800, 16'h0FF0, 16'h0100, 16'h0110},
        '{16'h0400, 16'h0000, 16'h0200, 16'h0100}, '{16'h0FFF, 16'h0000, 16'h0FFF, 16'h0FFF},
        '{16'h0800, 16'h0010, 16'h0008, 16'h0000}};
    // Sample, expected window flag
    logic [15:0] winTab [5][2] = '{'{16'h0150, 16'h0004}, '{16'h0250, 16'h0000},
        '{16'h00FF, 16'h0000}, '{16'h0200, 16'h0004}, '{16'h0100, 16'h0004}};

    arw_regs #(.SYNC_CYCLES(SYNC_N)) i_dut (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe),
        .regRdData(regRdData),
        .sampleValid(sampleValid),
        .sampleData(sampleData),
        .debugHalt(debugHalt),
        .convRun(convRun),
        .syncInProgress(syncInProgress),
        .irq(irq),
        .biasTrim(biasTrim),
        .linearityTrim(linearityTrim)
    );

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ****************************************
    // Register port and sample tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge core_clk);
        regWrStrobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge core_clk);
        regRdStrobe <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        rd(a, rdVal);
        `CHK(rdVal & m, e)
    endtask

    task automatic smp(input logic [11:0] d);
        @(posedge core_clk);
        sampleValid <= 1'b1;
        sampleData <= d;
        @(posedge core_clk);
        sampleValid <= 1'b0;
        sampleData <= ~d;
        #1;
    endtask

    task automatic waitSync(output int n);
        n = 0;
        while (syncInProgress !== 1'b0) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 40) begin
                numErrors++;
                $display("unexpected at %0t: sync busy never ended", $time);
                wrap_up();
            end
        end
    endtask

    task automatic wrCtl(input logic [15:0] d);
        int n;
        wr(OFS_CTRL, d);
        waitSync(n);
    endtask

    task automatic wrap_up();
        $display("Comparisons: %0d, mismatches: %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int cnt;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rstOfs[i]) rdChk(rstOfs[i], 16'hFFFF, 16'h0000);
        wr(OFS_WINLO, 16'h0100);
        `CHK(syncInProgress, 1'b1)
        waitSync(cnt);
        `CHK(cnt, int'(SYNC_N))
        rdChk(OFS_FLAG, 16'h0008, 16'h0008);
        wr(OFS_FLAG, 16'h0008);
        rdChk(OFS_FLAG, 16'h0008, 16'h0000);
        wr(OFS_WINHI, 16'h0200);
        rdChk(OFS_STATUS, 16'h0080, 16'h0080);
        waitSync(cnt);
        rdChk(OFS_WINLO, 16'hFFFF, 16'h0100);
        rdChk(OFS_WINHI, 16'hFFFF, 16'h0200);
        wr(OFS_FACT, 16'h05A5);
        rdChk(OFS_FACT, 16'hFFFF, 16'h05A5);
        `CHK(biasTrim, 3'h5)
        `CHK(linearityTrim, 8'hA5)
        wr(OFS_GAIN, 16'hFFFF);
        rdChk(OFS_GAIN, 16'hFFFF, 16'h0FFF);
        wr(OFS_MASK, 16'h0001);
        // Right and left layout, irq on done
        wrCtl(16'h0001);
        smp(12'hABC);
        `CHK(irq, 1'b1)
        rdChk(OFS_RESULT, 16'hFFFF, 16'h0ABC);
        rdChk(OFS_FLAG, 16'h0007, 16'h0000);
        `CHK(irq, 1'b0)
        wrCtl(16'h0003);
        smp(12'hABC);
        rdChk(OFS_RESULT, 16'hFFFF, 16'hABC0);
        // Overwrite of an unread result
        wrCtl(16'h0001);
        smp(12'h111);
        smp(12'h222);
        rdChk(OFS_FLAG, 16'h0007, 16'h0003);
        wr(OFS_FLAG, 16'h0001);
        `CHK(irq, 1'b0)
        rdChk(OFS_FLAG, 16'h0007, 16'h0002);
        wr(OFS_FLAG, 16'h0002);
        rdChk(OFS_FLAG, 16'h0007, 16'h0000);
        rdChk(OFS_RESULT, 16'hFFFF, 16'h0222);
        // Window monitor, inclusive bounds
        wrCtl(16'h0009);
        foreach (winTab[i]) begin
            smp(winTab[i][0][11:0]);
            rdChk(OFS_FLAG, 16'h0004, winTab[i][1]);
            rdChk(OFS_RESULT, 16'hFFFF, winTab[i][0]);
            rdChk(OFS_FLAG, 16'h0005, 16'h0000);
        end
        smp(12'h150);
        wr(OFS_FLAG, 16'h0004);
        rdChk(OFS_FLAG, 16'h0004, 16'h0000);
        rdChk(OFS_RESULT, 16'hFFFF, 16'h0150);
        // Offset then gain, saturated
        wrCtl(16'h0005);
        foreach (trimTab[i]) begin
            wr(OFS_GAIN, trimTab[i][0]);
            wr(OFS_OFFS, trimTab[i][1]);
            smp(trimTab[i][2][11:0]);
            rdChk(OFS_RESULT, 16'hFFFF, trimTab[i][3]);
        end
        // Two-sample accumulation without shift, then with a one-bit shift
        wrCtl(16'h0001);
        wr(OFS_AVG, 16'h0001);
        smp(12'h800);
        smp(12'h900);
        rdChk(OFS_RESULT, 16'hFFFF, 16'h1100);
        wr(OFS_AVG, 16'h0011);
        smp(12'h800);
        smp(12'h900);
        rdChk(OFS_RESULT, 16'hFFFF, 16'h0880);
        wr(OFS_AVG, 16'h0000);
        // Debug halt behaviour
        wr(OFS_DBG, 16'h0001);
        rdChk(OFS_DBG, 16'hFFFF, 16'h0000);
        @(posedge core_clk);
        debugHalt <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(convRun, 1'b0)
        smp(12'h333);
        rdChk(OFS_FLAG, 16'h0001, 16'h0000);
        wrCtl(16'h0000);
        wr(OFS_DBG, 16'h0001);
        rdChk(OFS_DBG, 16'hFFFF, 16'h0001);
        wrCtl(16'h0001);
        @(posedge core_clk);
        #1;
        `CHK(convRun, 1'b1)
        smp(12'h333);
        rdChk(OFS_RESULT, 16'hFFFF, 16'h0333);
        @(posedge core_clk);
        debugHalt <= 1'b0;
        wrap_up();
    end
endmodule
`undef CHK
`default_nettype wire
